/* File: src/gain_regmap_pkg.sv */
/*
  Constants for the dual-channel gain register bank: offsets, reset
  values, gain code limits and serial frame layout.
  Assumes nothing of its surroundings; imported by the bank module.
*/
package gain_regmap_pkg;
  // Register offsets, 7-bit address space
  localparam logic [6:0] ADDR_REVISION = 7'h00;
  localparam logic [6:0] ADDR_PART_ID = 7'h01;
  localparam logic [6:0] ADDR_SOFT_RESET = 7'h02;
  localparam logic [6:0] ADDR_SHUTDOWN = 7'h03;
  localparam logic [6:0] ADDR_BIAS_A = 7'h04;
  localparam logic [6:0] ADDR_GAIN_A = 7'h05;
  localparam logic [6:0] ADDR_BIAS_B = 7'h06;
  localparam logic [6:0] ADDR_GAIN_B = 7'h07;
  // Power-up values
  localparam logic [7:0] RST_SOFT_RESET = 8'h00;
  localparam logic [7:0] RST_SHUTDOWN = 8'h00;
  localparam logic [7:0] RST_BIAS = 8'h20;
  localparam logic [7:0] RST_GAIN = 8'h14;
  // Bit of the soft reset register that restores defaults
  localparam int SOFT_RESET_BIT = 0;
  // Gain code range and decode
  localparam logic [7:0] GAIN_CODE_MAX_DB = 8'h00;
  localparam logic [7:0] GAIN_CODE_MIN_DB = 8'h27;
  localparam logic signed [7:0] GAIN_TOP_DB = 8'sd30;
  localparam logic signed [7:0] GAIN_BOTTOM_DB = -8'sd9;
  // Frame: R/W bit, 7 address bits, 8 data bits, MSB first
  localparam logic [4:0] HDR_BITS = 5'h08;
  localparam logic [4:0] FRAME_BITS = 5'h10;
endpackage

/* File: src/gain_regmap.sv */
/*
  Register bank of a dual-channel variable-gain amplifier, with gain decode to decibels.
  Assumes a mode 0 serial host (sample on rising, shift on falling clock), chip select
  low, serial clock well below a quarter of core_clk; sclk, cs_n and sdi are resynchronised here, rstn is not.
*/
// Functional notes
// - Each channel gain is set independently from -9 dB to 30 dB in 1 dB steps.
// - Channel A gain comes from address 5h, channel B gain from 7h.
// - Gain code 0h selects the highest gain, 30 dB.
// - Gain code 27h selects the lowest gain, -9 dB.
// - Both gain registers power up at 14h and are read/write.
// - Bias registers at 4 and 6 are read/write, power up at 20h.
// - Soft reset (2) and shutdown (3) are read/write, power up at 00h.
// - Revision (0) and part identifier (1) are read-only fixed bytes.
// - Every access carries a seven-bit register address.
`timescale 1ns/1ps
`default_nettype none
module gain_regmap
  import gain_regmap_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h5a, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h61 // arbitrary value
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Serial pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // Register contents to the amplifier
  output logic [7:0] soft_reset_ctl,
  output logic [7:0] shutdown_ctl,
  output logic [7:0] bias_a,
  output logic [7:0] bias_b,
  output logic [7:0] gain_a_code,
  output logic [7:0] gain_b_code,
  // Decoded gain in dB, two's complement
  output logic signed [7:0] gain_a_db,
  output logic signed [7:0] gain_b_db
);

  // Two-stage synchronisers plus a history stage for edge detect
  logic [2:0] sclk_sync_r;
  logic [1:0] cs_sync_r;
  logic [1:0] sdi_sync_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sclk_sync_r <= 3'h0;
      cs_sync_r <= 2'h3;
      sdi_sync_r <= 2'h0;
    end
    else
    begin
      sclk_sync_r <= {sclk_sync_r[1:0], sclk};
      cs_sync_r <= {cs_sync_r[0], cs_n};
      sdi_sync_r <= {sdi_sync_r[0], sdi};
    end
  end
  logic sel;
  logic sclk_rise;
  logic sclk_fall;
  assign sel = !cs_sync_r[1];
  // Edges come from stages two and three only, never stage one
  assign sclk_rise = sel && sclk_sync_r[1] && !sclk_sync_r[2];
  assign sclk_fall = sel && !sclk_sync_r[1] && sclk_sync_r[2];
  // Frame shifter and bit counter
  logic [4:0] bit_cnt_r;
  logic [15:0] shift_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_cnt_r <= 5'h00;
      shift_r <= 16'h0000;
    end
    else if (!sel)
    begin
      bit_cnt_r <= 5'h00;
    end
    else if (sclk_rise && bit_cnt_r != FRAME_BITS)
    begin
      // Bits past the sixteenth are ignored
      bit_cnt_r <= bit_cnt_r + 5'h01;
      shift_r <= {shift_r[14:0], sdi_sync_r[1]};
    end
  end
  // Header decode: R/W bit then 7-bit address
  logic is_read;
  logic [6:0] acc_addr;
  logic hdr_done;
  logic wr_commit;
  assign is_read = shift_r[7]; // Header fills the low byte after the eighth edge
  assign acc_addr = shift_r[6:0];
  assign hdr_done = sclk_rise && bit_cnt_r == HDR_BITS - 5'h01;
  assign wr_commit = sclk_rise && bit_cnt_r == FRAME_BITS - 5'h01 && !shift_r[14];
  // At the last rising edge shift_r still holds header in [14:7]
  logic [6:0] wr_addr;
  assign wr_addr = shift_r[13:7];
  logic [7:0] wr_byte;
  assign wr_byte = {shift_r[6:0], sdi_sync_r[1]};
  // Writable registers; soft reset bit restores the others
  logic [7:0] soft_reset_r;
  logic [7:0] shutdown_r;
  logic [7:0] bias_a_r;
  logic [7:0] bias_b_r;
  logic [7:0] gain_a_r;
  logic [7:0] gain_b_r;
  logic soft_hit;
  assign soft_hit = wr_commit && wr_addr == ADDR_SOFT_RESET && wr_byte[SOFT_RESET_BIT];
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      soft_reset_r <= RST_SOFT_RESET;
      shutdown_r <= RST_SHUTDOWN;
      bias_a_r <= RST_BIAS;
      bias_b_r <= RST_BIAS;
      gain_a_r <= RST_GAIN;
      gain_b_r <= RST_GAIN;
    end
    else if (wr_commit)
    begin
      // Read-only and unmapped addresses fall through unchanged
      if (wr_addr == ADDR_SOFT_RESET)
        soft_reset_r <= wr_byte;
      else if (wr_addr == ADDR_SHUTDOWN)
        shutdown_r <= wr_byte;
      else if (wr_addr == ADDR_BIAS_A)
        bias_a_r <= wr_byte;
      else if (wr_addr == ADDR_GAIN_A)
        gain_a_r <= wr_byte;
      else if (wr_addr == ADDR_BIAS_B)
        bias_b_r <= wr_byte;
      else if (wr_addr == ADDR_GAIN_B)
        gain_b_r <= wr_byte;
      if (soft_hit)
      begin
        shutdown_r <= RST_SHUTDOWN;
        bias_a_r <= RST_BIAS;
        bias_b_r <= RST_BIAS;
        gain_a_r <= RST_GAIN;
        gain_b_r <= RST_GAIN;
      end
    end
  end
  assign soft_reset_ctl = soft_reset_r;
  assign shutdown_ctl = shutdown_r;
  assign bias_a = bias_a_r;
  assign bias_b = bias_b_r;
  assign gain_a_code = gain_a_r;
  assign gain_b_code = gain_b_r;
  // Read mux; unmapped addresses read as zero
  logic [7:0] rd_data;
  always_comb
  begin
    if (acc_addr == ADDR_REVISION)
      rd_data = REVISION_CODE;
    else if (acc_addr == ADDR_PART_ID)
      rd_data = PART_CODE;
    else if (acc_addr == ADDR_SOFT_RESET)
      rd_data = soft_reset_r;
    else if (acc_addr == ADDR_SHUTDOWN)
      rd_data = shutdown_r;
    else if (acc_addr == ADDR_BIAS_A)
      rd_data = bias_a_r;
    else if (acc_addr == ADDR_GAIN_A)
      rd_data = gain_a_r;
    else if (acc_addr == ADDR_BIAS_B)
      rd_data = bias_b_r;
    else if (acc_addr == ADDR_GAIN_B)
      rd_data = gain_b_r;
    else
      rd_data = 8'h00;
  end
  // Read data is snapshotted one cycle after the header completes
  logic load_pend_r;
  logic rd_phase_r;
  logic [7:0] tx_r;
  logic sdo_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      load_pend_r <= 1'b0;
      rd_phase_r <= 1'b0;
      tx_r <= 8'h00;
      sdo_r <= 1'b0;
    end
    else if (!sel)
    begin
      load_pend_r <= 1'b0;
      rd_phase_r <= 1'b0;
      sdo_r <= 1'b0;
    end
    else
    begin
      load_pend_r <= hdr_done;
      if (load_pend_r)
      begin
        tx_r <= rd_data;
        rd_phase_r <= is_read;
      end
      else if (sclk_fall && rd_phase_r && bit_cnt_r != FRAME_BITS)
      begin
        // Mode 0: drive each bit on the falling edge ahead of its sample
        sdo_r <= tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end
  assign sdo = sdo_r;
  assign sdo_oe = rd_phase_r;
  // Gain decode, saturating codes past 27h at the bottom step
  function automatic logic signed [7:0] code_to_db(input logic [7:0] code);
    if (code > GAIN_CODE_MIN_DB)
      code_to_db = GAIN_BOTTOM_DB;
    else
      code_to_db = GAIN_TOP_DB - $signed(code);
  endfunction
  logic signed [7:0] gain_a_db_r;
  logic signed [7:0] gain_b_db_r;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gain_a_db_r <= GAIN_TOP_DB - $signed(RST_GAIN);
      gain_b_db_r <= GAIN_TOP_DB - $signed(RST_GAIN);
    end
    else
    begin
      gain_a_db_r <= code_to_db(gain_a_r);
      gain_b_db_r <= code_to_db(gain_b_r);
    end
  end
  assign gain_a_db = gain_a_db_r;
  assign gain_b_db = gain_b_db_r;

  // Assertions
  property p_gain_linear;
    @(posedge core_clk) disable iff (!rstn)
    $past(gain_b_r) <= GAIN_CODE_MIN_DB |-> gain_b_db_r == GAIN_TOP_DB - $signed($past(gain_b_r));
  endproperty
  a_gain_linear: assert property (p_gain_linear) else $error("gain B decode wrong");
  property p_code_top;
    @(posedge core_clk) disable iff (!rstn)
    wr_commit && wr_addr == ADDR_GAIN_A && wr_byte == GAIN_CODE_MAX_DB && !soft_hit
      |-> ##2 gain_a_db_r == GAIN_TOP_DB;
  endproperty
  a_code_top: assert property (p_code_top) else $error("code 0 not 30 dB");
  property p_code_bottom;
    @(posedge core_clk) disable iff (!rstn)
    wr_commit && wr_addr == ADDR_GAIN_B && wr_byte == GAIN_CODE_MIN_DB
      |-> ##2 gain_b_db_r == GAIN_BOTTOM_DB;
  endproperty
  a_code_bottom: assert property (p_code_bottom) else $error("code 27h not -9 dB");
  property p_gain_a_write;
    @(posedge core_clk) disable iff (!rstn)
    wr_commit && wr_addr == ADDR_GAIN_A |=> gain_a_r == $past(wr_byte) && $stable(gain_b_r);
  endproperty
  a_gain_a_write: assert property (p_gain_a_write) else $error("gain A write lost");
  property p_gain_reset;
    @(posedge core_clk) disable iff (!rstn)
    !$past(rstn) |-> gain_a_r == RST_GAIN && gain_b_r == RST_GAIN;
  endproperty
  a_gain_reset: assert property (p_gain_reset) else $error("gain reset value");
  property p_bias_reset;
    @(posedge core_clk) disable iff (!rstn)
    !$past(rstn) |-> bias_a_r == RST_BIAS && bias_b_r == RST_BIAS;
  endproperty
  a_bias_reset: assert property (p_bias_reset) else $error("bias reset value");
  property p_ctl_reset;
    @(posedge core_clk) disable iff (!rstn)
    !$past(rstn) |-> soft_reset_r == RST_SOFT_RESET && shutdown_r == RST_SHUTDOWN;
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control reset value");
  property p_id_read;
    @(posedge core_clk) disable iff (!rstn)
    load_pend_r && sel && acc_addr == ADDR_REVISION |=> tx_r == REVISION_CODE;
  endproperty
  a_id_read: assert property (p_id_read) else $error("revision read wrong");
  property p_unmapped_write;
    @(posedge core_clk) disable iff (!rstn)
    wr_commit && wr_addr > ADDR_GAIN_B |=> $stable(gain_a_r) && $stable(bias_a_r);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("unmapped write hit");
  property p_sdo_shift;
    @(posedge core_clk) disable iff (!rstn)
    sclk_fall && rd_phase_r && !load_pend_r && bit_cnt_r != FRAME_BITS
      |=> sdo_r == $past(tx_r[7]) && sdo_oe;
  endproperty
  a_sdo_shift: assert property (p_sdo_shift) else $error("read bit not driven");
endmodule // gain_regmap
`default_nettype wire

/* File: tb/spi_host_model.sv */
/*
  Serial host model: frames of R/W bit, address, data, MSB first.
  Assumes core_clk from the bench; each sclk phase spans 6 core cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Timing reference
  input wire logic core_clk,
  // Serial pins
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  // Idle: deselected, clock low
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end

  // Wait n edges, then step off the edge
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // One frame, cut short when nb < 16; byte read from the data phase
  task automatic xfer(input logic [15:0] f, input int nb, output logic [7:0] rd);
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 15; i > 15 - nb; i--)
    begin
      sdi = f[i];
      wt(6);
      sclk = 1'b1;
      if (i < 8)
        rd[i] = sdo_oe ? sdo : 1'bx; // Undriven line must never match
      wt(6);
      sclk = 1'b0;
    end
    wt(6);
    cs_n = 1'b1;
    sdi = ~sdi; // Released line shows no stale bit
    wt(8);
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: tb/tb_gain_regmap.sv */
/*
  Self-checking bench for the gain register bank.
  Assumes the serial host model; all traffic goes over the serial pins.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gain_regmap;
  import gain_regmap_pkg::*;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  localparam logic [7:0] PART = 8'h96; // arbitrary value
  localparam logic [7:0] DFLT [8] = '{REV, PART, 8'h00, 8'h00, 8'h20, 8'h14, 8'h20, 8'h14};
  localparam logic [7:0] CODES [5] = '{8'h00, 8'h01, 8'h13, 8'h26, 8'h27};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic sclk, cs_n, sdi, sdo, sdo_oe;
  logic [7:0] soft_reset_ctl, shutdown_ctl, bias_a, bias_b, gain_a_code, gain_b_code;
  logic signed [7:0] gain_a_db, gain_b_db;
  logic [7:0] e;
  int err_count = 0;
  int total_checks = 0;

  // 25 MHz
  always #20 core_clk = ~core_clk;

  gain_regmap #(.REVISION_CODE(REV), .PART_CODE(PART)) gain_regmap_inst (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .soft_reset_ctl(soft_reset_ctl),
    .shutdown_ctl(shutdown_ctl), .bias_a(bias_a), .bias_b(bias_b),
    .gain_a_code(gain_a_code), .gain_b_code(gain_b_code),
    .gain_a_db(gain_a_db), .gain_b_db(gain_b_db));

  spi_host_model spi_host_model_inst (
    .core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    spi_host_model_inst.xfer({1'b0, a, d}, 16, v);
  endtask

  // Serial read compared against a value
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    spi_host_model_inst.xfer({1'b1, a, 8'h00}, 16, v);
    chk($sformatf("reg %h", a), v, exp);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard, far beyond the ~10k cycles the tests need
  initial
  begin
    repeat (60000) @(posedge core_clk);
    err_count++;
    final_report();
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    #1 rstn = 1'b1;
    spi_host_model_inst.wt(4);
    chk("gain_a_db", gain_a_db, 8'h0a);
    chk("sdo_oe", {7'h00, sdo_oe}, 8'h00);
    for (int a = 0; a < 8; a++)
      rchk(a[6:0], DFLT[a]);
    $display("test power-up values done");
    // Gain codes, channels written to different codes
    foreach (CODES[i])
    begin
      wr(ADDR_GAIN_A, CODES[i]);
      wr(ADDR_GAIN_B, 8'h27 - CODES[i]);
      chk("gain_a_code", gain_a_code, CODES[i]);
      chk("gain_b_code", gain_b_code, 8'h27 - CODES[i]);
      e = 8'd30 - CODES[i];
      chk("gain_a_db", gain_a_db, e);
      e = 8'd30 - (8'h27 - CODES[i]);
      chk("gain_b_db", gain_b_db, e);
      rchk(ADDR_GAIN_A, CODES[i]);
    end
    $display("test gain decode done");
    // Every address written, bit0 clear so no soft reset
    for (int a = 0; a < 8; a++)
      wr(a[6:0], 8'h30 + 8'(2 * a));
    wr(7'h40, 8'h55);
    for (int a = 0; a < 8; a++)
      rchk(a[6:0], (a < 2) ? DFLT[a] : 8'h30 + 8'(2 * a));
    rchk(7'h40, 8'h00);
    rchk(7'h7f, 8'h00);
    chk("bias_b", bias_b, 8'h3c);
    chk("shutdown_ctl", shutdown_ctl, 8'h36);
    $display("test access kinds done");
    // Soft reset restores 3..7, keeps its own byte
    wr(ADDR_SOFT_RESET, 8'h01);
    chk("soft_reset_ctl", soft_reset_ctl, 8'h01);
    for (int a = 3; a < 8; a++)
      rchk(a[6:0], DFLT[a]);
    // Frame cut one bit short writes nothing
    spi_host_model_inst.xfer({1'b0, ADDR_BIAS_A, 8'h77}, 15, e);
    rchk(ADDR_BIAS_A, 8'h20);
    $display("test soft reset and short frame done");
    // Codes past 27h are stored as written, decode stays at the bottom step
    wr(ADDR_GAIN_A, 8'h3f);
    chk("gain_a_code", gain_a_code, 8'h3f);
    chk("gain_a_db", gain_a_db, 8'hf7);
    chk("bias_a", bias_a, 8'h20);
    chk("sdo", {7'h00, sdo}, 8'h00);
    // Reset in mid-run brings back the power-up values
    rstn = 1'b0;
    spi_host_model_inst.wt(3);
    chk("gain_a_code", gain_a_code, 8'h14);
    chk("gain_a_db", gain_a_db, 8'h0a);
    chk("sdo_oe", {7'h00, sdo_oe}, 8'h00);
    rstn = 1'b1;
    spi_host_model_inst.wt(4);
    chk("soft_reset_ctl", soft_reset_ctl, 8'h00);
    chk("gain_b_code", gain_b_code, 8'h14);
    rchk(ADDR_GAIN_A, 8'h14);
    $display("test saturation and mid-run reset done");
    final_report();
  end
endmodule // tb_gain_regmap
`default_nettype wire
